// File: logic/bcl_config_loader.v
// configuration load logic: master serial and synchronous peripheral modes
// Summary of operation
// - master serial: sample serial input on the rising edge after the presenting edge
// - forward preamble and overflow to chain output 1.5 clocks later, on falling edge
// - fast-rate option multiplies driven config_clock by eight, several bits into frame
// - mode_select_pins 000 select master serial mode
// - memory enable from low_during_config_out or done; former stays high afterwards
// - bytes after the first are captured every eighth consecutive rising edge
// - acknowledge goes high one config_clock period on the capturing edge
// - before init goes high acknowledge is only weakly pulled up, not driven
// - peripheral mode serializes captured bytes onto the chain output
// - mode_select_pins 011 select synchronous peripheral mode
// - unused outputs are high impedance with pull-up before and during configuration
// - after configuration unused cells are inputs with weak pull-up
// - no reset pin; a user pin may drive global_set_reset_net
// - global_output_float_net floats all outputs with no low-power state
// - readback_trigger high before finish starts the first readback at finish
module bcl_config_loader #(
  parameter CHAIN_LEN = 16
) (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // configuration pins
  input wire [2:0] modeSelectPins,
  input wire initPin,
  input wire activeHighChipSelect,
  input wire configClockIn,
  output reg configClockOut,
  output reg configClockOe,
  input wire serialConfigIn,
  input wire [7:0] configByteInputs,
  output reg serialChainOut,
  output reg ackOut,
  output reg ackOe,
  output reg lowDuringConfigOut,
  output reg doneOut,
  // global nets and user pins
  input wire userResetPin,
  input wire userFloatPin,
  input wire readbackTrigger,
  output reg globalSetResetNet,
  output reg globalOutputFloatNet,
  output reg userPullupEn,
  output reg userOutputsOe,
  output reg readbackStart
);
`include "bcl_regs.vh"
  localparam ST_IDLE = 2'd0;
  localparam ST_MSER = 2'd1;
  localparam ST_SPER = 2'd2;
  localparam ST_DONE = 2'd3;
  localparam integer SLOW_HALF_I = `BCL_SLOW_HALF;
  localparam integer FAST_HALF_I = `BCL_SLOW_HALF / `BCL_FAST_FACTOR;
  // the divider counts in eight bits; both half periods sit well below 256
  localparam [7:0] SLOW_HALF = SLOW_HALF_I[7:0];
  localparam [7:0] FAST_HALF = FAST_HALF_I[7:0];
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // all single-bit level pins share one two-stage chain, so their delays match the link clock's
  reg [13:0] syncA_r;
  reg [13:0] syncB_r;
  reg [7:0] byteA_r;
  reg [7:0] byteB_r;
  reg clkPrev_r;
  always @(posedge core_clk) begin
    if (srst) begin
      syncA_r <= 14'h0000;
      syncB_r <= 14'h0000;
      byteA_r <= 8'h00;
      byteB_r <= 8'h00;
      clkPrev_r <= 1'b0;
    end else begin
      syncA_r <= {modeSelectPins, initPin, activeHighChipSelect, configClockIn, serialConfigIn,
                  userResetPin, userFloatPin, readbackTrigger, 4'h0};
      syncB_r <= syncA_r;
      byteA_r <= configByteInputs;
      byteB_r <= byteA_r;
      clkPrev_r <= syncB_r[8];
    end
  end
  wire [2:0] modeS = syncB_r[13:11];
  wire initS = syncB_r[10];
  wire csS = syncB_r[9];
  wire extClkS = syncB_r[8];
  wire dinS = syncB_r[7];
  wire rstPinS = syncB_r[6];
  wire floatPinS = syncB_r[5];
  wire trigS = syncB_r[4];
  wire extRise = extClkS & ~clkPrev_r;
  wire extFall = ~extClkS & clkPrev_r;
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_r;
  reg [1:0] state_r;
  reg [2:0] mode_r;
  reg [31:0] byteCount_r;
  reg addrPhase_r;
  reg addrWrite_r;
  reg [3:0] addrIdx_r;
  // ----------------------------------------------------------------
  // master clock generator
  // ----------------------------------------------------------------
  reg [7:0] divCnt_r;
  reg [7:0] bitCount_r;
  wire fastOn = ctrl_r[`BCL_CTRL_FAST] && (bitCount_r >= `BCL_FAST_START_BITS);
  wire [7:0] halfLim = fastOn ? FAST_HALF : SLOW_HALF;
  wire mserActive = (state_r == ST_MSER);
  wire divWrap = (divCnt_r >= halfLim - 8'd1);
  wire mRise = mserActive && divWrap && !configClockOut;
  wire mFall = mserActive && divWrap && configClockOut;
  wire sperActive = (state_r == ST_SPER);
  wire cRise = mserActive ? mRise : (sperActive & extRise);
  wire cFall = mserActive ? mFall : (sperActive & extFall);
  // ----------------------------------------------------------------
  // data path: serial capture, byte capture, chain pipeline
  // ----------------------------------------------------------------
  reg [2:0] phase_r;
  reg [7:0] shift_r;
  reg [CHAIN_LEN-1:0] frame_r;
  reg pipe_r;
  reg firstEdge_r;
  // the byte bus lags by the same two stages, so a detected rise sees the byte set up for it
  wire [7:0] capByte = byteB_r;
  always @(posedge core_clk) begin
    if (srst) begin
      divCnt_r <= 8'h00;
      configClockOut <= 1'b0;
      configClockOe <= 1'b0;
      bitCount_r <= 8'h00;
      phase_r <= 3'd0;
      shift_r <= 8'h00;
      frame_r <= {CHAIN_LEN{1'b0}};
      pipe_r <= 1'b1;
      serialChainOut <= 1'b1;
      ackOut <= 1'b1;
      ackOe <= 1'b0;
      firstEdge_r <= 1'b1;
      byteCount_r <= 32'h00000000;
    end else begin
      configClockOe <= mserActive;
      ackOe <= sperActive && initS;
      if (mserActive) begin
        divCnt_r <= divWrap ? 8'h00 : divCnt_r + 8'd1;
        if (divWrap)
          configClockOut <= ~configClockOut;
      end else begin
        divCnt_r <= 8'h00;
        configClockOut <= 1'b0;
      end
      if (state_r == ST_IDLE) begin
        firstEdge_r <= 1'b1;
        phase_r <= 3'd0;
        bitCount_r <= 8'h00;
      end
      if (cRise) begin
        if (mserActive) begin
          // the memory presents on this edge what we take on the next rise; now we take the previous edge's bit
          if (firstEdge_r)
            firstEdge_r <= 1'b0;
          else begin
            pipe_r <= dinS;
            frame_r <= {frame_r[CHAIN_LEN-2:0], dinS};
            if (bitCount_r != 8'hFF)
              bitCount_r <= bitCount_r + 8'd1;
          end
        end else begin
          phase_r <= phase_r + 3'd1;
          if (phase_r == 3'd0) begin
            shift_r <= {capByte[6:0], 1'b0};
            pipe_r <= capByte[7];
            frame_r <= {frame_r[CHAIN_LEN-2:0], capByte[7]};
            byteCount_r <= byteCount_r + 32'd1;
            ackOut <= 1'b1;
          end else begin
            shift_r <= {shift_r[6:0], 1'b0};
            pipe_r <= shift_r[7];
            frame_r <= {frame_r[CHAIN_LEN-2:0], shift_r[7]};
            ackOut <= 1'b0;
          end
        end
      end else if (!sperActive || !initS) begin
        // an undriven acknowledge reads as its pull-up level
        ackOut <= 1'b1;
      end else if (!ackOe) begin
        // once driven it idles low, so every capture shows as a fresh pulse
        ackOut <= 1'b0;
      end
      if (cFall)
        serialChainOut <= pipe_r;
    end
  end
  // ----------------------------------------------------------------
  // mode sequencing and global nets
  // ----------------------------------------------------------------
  wire finishReq = ctrl_r[`BCL_CTRL_DONE];
  reg trigSeen_r;
  always @(posedge core_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      mode_r <= 3'b111;
      lowDuringConfigOut <= 1'b1;
      doneOut <= 1'b0;
      globalSetResetNet <= 1'b0;
      globalOutputFloatNet <= 1'b1;
      userPullupEn <= 1'b1;
      userOutputsOe <= 1'b0;
      readbackStart <= 1'b0;
      trigSeen_r <= 1'b0;
    end else begin
      readbackStart <= 1'b0;
      globalSetResetNet <= rstPinS;
      case (state_r)
        ST_IDLE: begin
          userOutputsOe <= 1'b0;
          userPullupEn <= 1'b1;
          globalOutputFloatNet <= 1'b1;
          if (ctrl_r[`BCL_CTRL_START] && csS && initS) begin
            mode_r <= modeS;
            // unsupported pins leave the loader idle and the memory disabled
            if (modeS == `BCL_MODE_MSER) begin
              state_r <= ST_MSER;
              lowDuringConfigOut <= 1'b0;
            end else if (modeS == `BCL_MODE_SPER) begin
              state_r <= ST_SPER;
              lowDuringConfigOut <= 1'b0;
            end
          end
        end
        ST_MSER, ST_SPER: begin
          trigSeen_r <= trigS;
          if (finishReq || !csS) begin
            state_r <= ST_DONE;
            lowDuringConfigOut <= 1'b1;
            doneOut <= 1'b1;
            readbackStart <= trigS;
          end
        end
        default: begin
          lowDuringConfigOut <= 1'b1;
          userPullupEn <= 1'b1;
          globalOutputFloatNet <= floatPinS;
          userOutputsOe <= ~floatPinS;
          trigSeen_r <= trigS;
          if (trigS && !trigSeen_r)
            readbackStart <= 1'b1;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (srst) begin
      ctrl_r <= `BCL_CTRL_RESET;
      addrPhase_r <= 1'b0;
      addrWrite_r <= 1'b0;
      addrIdx_r <= 4'h0;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // start clears itself once the loader leaves idle; a write in the same cycle still wins
      if (ctrl_r[`BCL_CTRL_START] && state_r != ST_IDLE)
        ctrl_r[`BCL_CTRL_START] <= 1'b0;
      if (addrPhase_r && addrWrite_r && addrIdx_r == `BCL_ADDR_CTRL)
        ctrl_r <= hwdata[7:0];
      addrPhase_r <= hsel && hready && htrans[1];
      addrWrite_r <= hwrite;
      addrIdx_r <= haddr[3:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        if (haddr[3:0] == `BCL_ADDR_CTRL)
          hrdata <= {24'h000000, ctrl_r};
        else if (haddr[3:0] == `BCL_ADDR_STATUS)
          hrdata <= {21'h0, mode_r, 2'b00, state_r, doneOut, lowDuringConfigOut, ackOut, serialChainOut};
        else if (haddr[3:0] == `BCL_ADDR_BYTES)
          hrdata <= byteCount_r;
        else
          hrdata <= 32'h00000000;
      end
    end
  end
endmodule // bcl_config_loader

// File: logic/bcl_regs.vh
// constants of the bitstream configuration loader
`ifndef BCL_REGS_VH
`define BCL_REGS_VH
// register byte addresses
`define BCL_ADDR_CTRL 4'h0
`define BCL_ADDR_STATUS 4'h4
`define BCL_ADDR_BYTES 4'h8
// control fields
`define BCL_CTRL_START 0
`define BCL_CTRL_FAST 1
`define BCL_CTRL_DONE 2
`define BCL_CTRL_GSR 3
`define BCL_CTRL_GTS 4
`define BCL_CTRL_LDCSEL 5
`define BCL_CTRL_RESET 8'h00
// mode pin patterns
`define BCL_MODE_MSER 3'b000
`define BCL_MODE_SPER 3'b011
// timing
`define BCL_CORE_MHZ 20
`define BCL_SLOW_KHZ 625
`define BCL_SLOW_HALF ((`BCL_CORE_MHZ * 1000) / (2 * `BCL_SLOW_KHZ))
`define BCL_FAST_FACTOR 8
`define BCL_FAST_START_BITS 8
`endif

// File: verification/bcl_loader_checker_assertions.sv
// port checker of the configuration loader
`include "bcl_regs.vh"
module bcl_loader_checker (
  // clock and reset
  input wire core_clk,
  input wire srst,
  // pins and nets
  input wire [2:0] modeSelectPins,
  input wire initPin,
  input wire userResetPin,
  input wire configClockOe,
  input wire ackOut,
  input wire ackOe,
  input wire lowDuringConfigOut,
  input wire doneOut,
  input wire globalSetResetNet,
  input wire globalOutputFloatNet,
  input wire userPullupEn,
  input wire userOutputsOe,
  input wire readbackStart
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_ackWeak; !initPin [*4] |-> !ackOe && ackOut; endproperty
  a_ackWeak: assert property (p_ackWeak) else $error("ack driven before init");
  property p_ackPulse; $rose(ackOut) && ackOe |-> ackOut [*8] ##1 !ackOut; endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack not one link period");
  property p_gsr; userResetPin [*4] |-> globalSetResetNet; endproperty
  a_gsr: assert property (p_gsr) else $error("reset pin not on set/reset net");
  property p_float; globalOutputFloatNet [*2] |-> !userOutputsOe; endproperty
  a_float: assert property (p_float) else $error("outputs driven while floated");
  property p_hiz; !doneOut [*2] |-> !userOutputsOe && userPullupEn; endproperty
  a_hiz: assert property (p_hiz) else $error("outputs driven before finish");
  property p_ldc; doneOut [*3] |-> lowDuringConfigOut; endproperty
  a_ldc: assert property (p_ldc) else $error("low-during-config not high after");
  property p_rdbk; readbackStart |=> !readbackStart && doneOut; endproperty
  a_rdbk: assert property (p_rdbk) else $error("readback start misplaced");
  property p_mser; $rose(configClockOe) |-> modeSelectPins == `BCL_MODE_MSER; endproperty
  a_mser: assert property (p_mser) else $error("clock driven outside master mode");
  c_ack: cover property ($rose(ackOut) && ackOe);
  c_done: cover property ($rose(doneOut));
  c_clk: cover property ($rose(configClockOe));
endmodule // bcl_loader_checker

bind bcl_config_loader bcl_loader_checker u_chk (.core_clk, .srst, .modeSelectPins, .initPin, .userResetPin,
  .configClockOe, .ackOut, .ackOe, .lowDuringConfigOut, .doneOut, .globalSetResetNet, .globalOutputFloatNet,
  .userPullupEn, .userOutputsOe, .readbackStart);

// File: verification/bcl_serial_mem.sv
// behavioural serial configuration memory
module bcl_serial_mem (
  // memory pins
  input wire memClk,
  input wire memEnN,
  output logic memData
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // bit stream
  // ----------
  logic [31:0] image = 32'hA5C30F96;
  int addr = 0;
  initial memData = 1'h1;
  always @(posedge memClk or posedge memEnN) begin
    // a released line shows the inverse, never a stale bit the loader could trust
    if (memEnN) memData <= ~memData;
    else begin
      addr <= addr + 1;
      memData <= image[(addr + 1) % 32];
    end
  end
endmodule // bcl_serial_mem

// File: verification/bcl_loader_tb.sv
// self-checking bench of the configuration loader
`include "bcl_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // -------------
  // nets and rows
  // -------------
  logic core_clk = 0, srst = 1, hsel = 0, hwrite = 0, initPin = 0, configClockIn = 0, rbSeen = 0;
  logic activeHighChipSelect = 1;
  logic userResetPin = 0, userFloatPin = 0, readbackTrigger = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] modeSelectPins = `BCL_MODE_SPER;
  logic [7:0] configByteInputs = 8'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, chain = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, configClockOut, configClockOe, serialConfigIn, ackOut, ackOe, lowDuringConfigOut;
  wire doneOut, globalSetResetNet, globalOutputFloatNet, userPullupEn, userOutputsOe, readbackStart;
  wire serialChainOut;
  int n_errors = 0, samples_checked = 0, cycles = 0, ackCnt = 0;
  time tEdge[14];
  typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} bcl_row_t;
  bcl_row_t rows[5] = '{'{0, `BCL_ADDR_CTRL, 0, 0}, '{0, `BCL_ADDR_BYTES, 0, 0},
    '{1, 32'hC, 32'hFFFFFFFF, 0}, '{1, `BCL_ADDR_CTRL, 32'h2, 32'h2}, '{1, `BCL_ADDR_CTRL, 0, 0}};
  bcl_config_loader #(.CHAIN_LEN(16)) dut (.core_clk, .srst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .modeSelectPins, .initPin,
    .activeHighChipSelect, .configClockIn, .configClockOut, .configClockOe, .serialConfigIn,
    .configByteInputs, .serialChainOut, .ackOut, .ackOe, .lowDuringConfigOut, .doneOut, .userResetPin,
    .userFloatPin, .readbackTrigger, .globalSetResetNet, .globalOutputFloatNet, .userPullupEn,
    .userOutputsOe, .readbackStart);
  bcl_serial_mem mem (.memClk(configClockOut), .memEnN(lowDuringConfigOut), .memData(serialConfigIn));
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (ackOe && $rose(ackOut)) ackCnt++;
    if (readbackStart) rbSeen = 1'h1;
    if (cycles == 5000) begin
      n_errors++;
      close_out;
    end
  end
  // -----
  // tasks
  // -----
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask
  // link clock moves on core edges, eight cycles a period, so the ack width is exact;
  // the downstream device samples the chain output just as each rise is driven
  task link(input int n);
    repeat (n) begin
      repeat (4) @(posedge core_clk);
      chain <= {chain[30:0], serialChainOut};
      configClockIn <= 1'h1;
      repeat (4) @(posedge core_clk);
      configClockIn <= 1'h0;
    end
  endtask
  task close_out;
    $display("TB: errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // --------
  // sequence
  // --------
  initial begin
    repeat (8) @(posedge core_clk);
    srst <= 1'h0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'h1, rows[i].a, rows[i].d);
      bus(1'h0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    $display("TB: register rows done");
    initPin <= 1'h1;
    readbackTrigger <= 1'h1;
    bus(1'h1, `BCL_ADDR_CTRL, 32'h1);
    modeSelectPins <= 3'h5;
    repeat (10) @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      configByteInputs <= 8'hA1 + 8'(i);
      link(8);
    end
    // first sample is the idle level, then the stream MSB first, one rise behind
    chk(chain, 32'hD0D151D2);
    @(posedge core_clk);
    bus(1'h0, `BCL_ADDR_BYTES, 32'h0);
    chk(rd, 32'h4);
    chk(ackCnt, 32'h4);
    bus(1'h0, `BCL_ADDR_STATUS, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h2);
    chk({29'h0, rd[10:8]}, {29'h0, `BCL_MODE_SPER});
    // ten trailing rises plus one for the single downstream device
    link(11);
    @(posedge core_clk);
    bus(1'h1, `BCL_ADDR_CTRL, 32'h4);
    repeat (10) @(posedge core_clk);
    chk({29'h0, doneOut, lowDuringConfigOut, rbSeen}, 32'h7);
    userFloatPin <= 1'h1;
    userResetPin <= 1'h1;
    repeat (6) @(posedge core_clk);
    chk({30'h0, globalSetResetNet, userOutputsOe}, 32'h2);
    userFloatPin <= 1'h0;
    repeat (6) @(posedge core_clk);
    chk({31'h0, userOutputsOe}, 32'h1);
    chk({31'h0, userPullupEn}, 32'h1);
    $display("TB: peripheral load done");
    srst <= 1'h1;
    userResetPin <= 1'h0;
    modeSelectPins <= `BCL_MODE_MSER;
    repeat (8) @(posedge core_clk);
    srst <= 1'h0;
    @(posedge core_clk);
    bus(1'h1, `BCL_ADDR_CTRL, 32'h3);
    for (int i = 0; i < 14; i++) begin
      @(posedge configClockOut);
      tEdge[i] = $time;
    end
    chk(32'(tEdge[1] - tEdge[0]), 2 * `BCL_SLOW_HALF * 50);
    chk(32'(tEdge[13] - tEdge[12]), 2 * `BCL_SLOW_HALF * 50 / `BCL_FAST_FACTOR);
    @(posedge core_clk);
    bus(1'h0, `BCL_ADDR_STATUS, 32'h0);
    chk({30'h0, rd[5:4]}, 32'h1);
    $display("TB: master clock done");
    close_out;
  end
endmodule // testbench
